// ==== design/iors_regs.svh ====
// Register offsets, field positions, reset values and bit masks of the I/O register space.
// Summary of operation
// - Lower 32 addresses accept bit set/clear.
// - Lower range supports single-bit test for skip.
// - Flag bits clear on written one.
// - Bit operations touch only the addressed bit.
// - Bit operations limited to addresses 0x00-0x1F.
`ifndef IORS_REGS_SVH
`define IORS_REGS_SVH

`define IORS_CONVERTER_CONTROL_B 6'h03
`define IORS_CONVERTER_RESULT_LOW 6'h04
`define IORS_CONVERTER_RESULT_HIGH 6'h05
`define IORS_CONVERTER_CONTROL_STATUS_A 6'h06
`define IORS_CONVERTER_INPUT_SELECT 6'h07
`define IORS_COMPARATOR_CONTROL_STATUS 6'h08
`define IORS_DIGITAL_INPUT_DISABLE 6'h14
`define IORS_PIN_CHANGE_MASK 6'h15
`define IORS_PORT_INPUT_PINS 6'h16
`define IORS_PORT_DIRECTION 6'h17
`define IORS_PORT_OUTPUT_LATCH 6'h18
`define IORS_EEPROM_DATA 6'h1d
`define IORS_EEPROM_ADDRESS 6'h1e
`define IORS_WATCHDOG_CONTROL 6'h21
`define IORS_CLOCK_PRESCALE 6'h26
`define IORS_GENERAL_TIMER_CONTROL 6'h28
`define IORS_TIMER_COMPARE_B 6'h29
`define IORS_DEBUG_DATA 6'h2e
`define IORS_TIMER_CONTROL_A 6'h2f
`define IORS_OSCILLATOR_TRIM 6'h31
`define IORS_TIMER_COUNT 6'h32
`define IORS_TIMER_CONTROL_B 6'h33
`define IORS_RESET_CAUSE_FLAGS 6'h34
`define IORS_CORE_CONTROL 6'h35
`define IORS_TIMER_COMPARE_A 6'h36
`define IORS_SELF_PROGRAM_CONTROL 6'h37
`define IORS_TIMER_INTERRUPT_FLAGS 6'h38
`define IORS_TIMER_INTERRUPT_MASK 6'h39
`define IORS_EXTERNAL_INTERRUPT_FLAGS 6'h3a
`define IORS_EXTERNAL_INTERRUPT_MASK 6'h3b
`define IORS_STACK_POINTER_LOW 6'h3d
`define IORS_CORE_STATUS_FLAGS 6'h3f

// Highest address that accepts bit set, bit clear and bit test.
`define IORS_BIT_ACCESS_TOP 6'h1f

// Flag positions cleared by a written one, and the port width.
`define IORS_CONVERTER_DONE_BIT 4
`define IORS_COMPARATOR_EVENT_BIT 4
`define IORS_WATCHDOG_EVENT_BIT 7
`define IORS_PORT_WIDTH 6

// Writable bit masks; reserved positions read as zero.
`define IORS_MASK_CONVERTER_CONTROL_B 8'h47
`define IORS_MASK_CONVERTER_CONTROL_STATUS_A 8'hef
`define IORS_MASK_CONVERTER_INPUT_SELECT 8'h63
`define IORS_MASK_COMPARATOR_CONTROL_STATUS 8'hcb
`define IORS_MASK_SIX_BITS 8'h3f
`define IORS_MASK_EEPROM_CONTROL 8'h3f
`define IORS_MASK_CLOCK_PRESCALE 8'h8f
`define IORS_MASK_GENERAL_TIMER_CONTROL 8'h81
`define IORS_MASK_TIMER_CONTROL_A 8'hf3
`define IORS_MASK_TIMER_CONTROL_B 8'hcf
`define IORS_MASK_RESET_CAUSE_FLAGS 8'h0f
`define IORS_MASK_CORE_CONTROL 8'h7b
`define IORS_MASK_SELF_PROGRAM_CONTROL 8'h1f
`define IORS_MASK_TIMER_FLAGS 8'h0e
`define IORS_MASK_EXTERNAL_FLAGS 8'h60
`define IORS_MASK_WATCHDOG_RW 8'h7f
`define IORS_MASK_ALL 8'hff

`define IORS_RESET_VALUE 8'h00

`endif

// ==== design/iors_pkg.sv ====
// Types shared by the I/O register space and its bench.
package iors_pkg;

  typedef enum logic [2:0] {
    IORS_OP_NONE,
    IORS_OP_READ,
    IORS_OP_WRITE,
    IORS_OP_SET_BIT,
    IORS_OP_CLEAR_BIT,
    IORS_OP_TEST_BIT
  } iors_op_type;

  typedef struct packed {
    iors_op_type op;
    logic [5:0] addr;
    logic [2:0] bit_sel;
    logic [7:0] wdata;
  } iors_req_type;

  typedef struct packed {
    logic [7:0] rdata;
    logic bit_value;
    logic bit_valid;
  } iors_rsp_type;

  // Hardware-set flag events coming from the peripherals.
  typedef struct packed {
    logic converter_done;
    logic comparator_event;
    logic watchdog_event;
    logic timer_overflow;
    logic timer_match_a;
    logic timer_match_b;
    logic external_event;
    logic pin_change_event;
    logic [3:0] reset_causes;
  } iors_event_type;

endpackage : iors_pkg

// ==== design/iors_space.sv ====
// I/O register space: decode, byte access, bit set/clear/test and write-one-to-clear flags.
`include "iors_regs.svh"

module iors_space (
  input wire logic sys_clk, // Core clock, 25 MHz.
  input wire logic arst_n, // Asynchronous reset, active low.
  input wire iors_pkg::iors_req_type req, // Request from the core, one cycle each.
  input wire iors_pkg::iors_event_type events, // Flag set pulses from peripherals.
  input wire logic [15:0] converter_result, // Conversion result from the converter.
  input wire logic [7:0] timer_value, // Running counter value.
  input wire logic [5:0] port_pins, // Raw port pin levels.
  output iors_pkg::iors_rsp_type rsp, // Registered answer to a read or bit test.
  output logic [7:0] port_direction, // Direction latch, one means output.
  output logic [7:0] port_output_latch, // Port output and pull-up latch.
  output logic [7:0] core_status_flags, // Status register seen by the core.
  output logic [7:0] stack_pointer_low // Stack pointer low byte.
);

  ////////////////////////////////////////////////////////////////////////////
  // Storage and pin synchroniser.

  logic [7:0] regs [0:63];
  logic [5:0] pin_meta;
  logic [5:0] pin_sync;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_meta <= 6'h00;
      pin_sync <= 6'h00;
    end else begin
      pin_meta <= port_pins;
      pin_sync <= pin_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decode.

  // Writable mask per address; zero for reserved addresses and read-only ones.
  function automatic logic [7:0] write_mask(input logic [5:0] a);
    case (a)
      `IORS_CONVERTER_CONTROL_B: write_mask = `IORS_MASK_CONVERTER_CONTROL_B;
      `IORS_CONVERTER_CONTROL_STATUS_A: write_mask = `IORS_MASK_CONVERTER_CONTROL_STATUS_A;
      `IORS_CONVERTER_INPUT_SELECT: write_mask = `IORS_MASK_CONVERTER_INPUT_SELECT;
      `IORS_COMPARATOR_CONTROL_STATUS: write_mask = `IORS_MASK_COMPARATOR_CONTROL_STATUS;
      `IORS_DIGITAL_INPUT_DISABLE: write_mask = `IORS_MASK_SIX_BITS;
      `IORS_PIN_CHANGE_MASK: write_mask = `IORS_MASK_SIX_BITS;
      `IORS_PORT_DIRECTION: write_mask = `IORS_MASK_SIX_BITS;
      `IORS_PORT_OUTPUT_LATCH: write_mask = `IORS_MASK_SIX_BITS;
      `IORS_EEPROM_DATA: write_mask = `IORS_MASK_ALL;
      `IORS_EEPROM_ADDRESS: write_mask = `IORS_MASK_SIX_BITS;
      `IORS_WATCHDOG_CONTROL: write_mask = `IORS_MASK_WATCHDOG_RW;
      `IORS_CLOCK_PRESCALE: write_mask = `IORS_MASK_CLOCK_PRESCALE;
      `IORS_GENERAL_TIMER_CONTROL: write_mask = `IORS_MASK_GENERAL_TIMER_CONTROL;
      `IORS_TIMER_COMPARE_B: write_mask = `IORS_MASK_ALL;
      `IORS_DEBUG_DATA: write_mask = `IORS_MASK_ALL;
      `IORS_TIMER_CONTROL_A: write_mask = `IORS_MASK_TIMER_CONTROL_A;
      `IORS_OSCILLATOR_TRIM: write_mask = `IORS_MASK_ALL;
      `IORS_TIMER_COUNT: write_mask = `IORS_MASK_ALL;
      `IORS_TIMER_CONTROL_B: write_mask = `IORS_MASK_TIMER_CONTROL_B;
      `IORS_CORE_CONTROL: write_mask = `IORS_MASK_CORE_CONTROL;
      `IORS_TIMER_COMPARE_A: write_mask = `IORS_MASK_ALL;
      `IORS_SELF_PROGRAM_CONTROL: write_mask = `IORS_MASK_SELF_PROGRAM_CONTROL;
      `IORS_TIMER_INTERRUPT_MASK: write_mask = `IORS_MASK_TIMER_FLAGS;
      `IORS_EXTERNAL_INTERRUPT_MASK: write_mask = `IORS_MASK_EXTERNAL_FLAGS;
      `IORS_STACK_POINTER_LOW: write_mask = `IORS_MASK_ALL;
      `IORS_CORE_STATUS_FLAGS: write_mask = `IORS_MASK_ALL;
      default: write_mask = 8'h00;
    endcase
  endfunction

  // Positions cleared by a written one.
  function automatic logic [7:0] clear_mask(input logic [5:0] a);
    case (a)
      `IORS_CONVERTER_CONTROL_STATUS_A: clear_mask = 8'h01 << `IORS_CONVERTER_DONE_BIT;
      `IORS_COMPARATOR_CONTROL_STATUS: clear_mask = 8'h01 << `IORS_COMPARATOR_EVENT_BIT;
      `IORS_WATCHDOG_CONTROL: clear_mask = 8'h01 << `IORS_WATCHDOG_EVENT_BIT;
      `IORS_RESET_CAUSE_FLAGS: clear_mask = `IORS_MASK_RESET_CAUSE_FLAGS;
      `IORS_TIMER_INTERRUPT_FLAGS: clear_mask = `IORS_MASK_TIMER_FLAGS;
      `IORS_EXTERNAL_INTERRUPT_FLAGS: clear_mask = `IORS_MASK_EXTERNAL_FLAGS;
      default: clear_mask = 8'h00;
    endcase
  endfunction

  // Value the core sees at an address; reserved addresses and bits read as zero.
  function automatic logic [7:0] read_value(input logic [5:0] a);
    case (a)
      `IORS_CONVERTER_RESULT_LOW: read_value = converter_result[7:0];
      `IORS_CONVERTER_RESULT_HIGH: read_value = converter_result[15:8];
      `IORS_PORT_INPUT_PINS: read_value = {2'b00, pin_sync};
      `IORS_TIMER_COUNT: read_value = timer_value;
      default: read_value = regs[a] & (write_mask(a) | clear_mask(a));
    endcase
  endfunction

  wire logic [5:0] addr = req.addr;
  wire logic bit_range = (addr <= `IORS_BIT_ACCESS_TOP);
  wire logic [7:0] bit_onehot = 8'h01 << req.bit_sel;
  wire logic do_write = (req.op == iors_pkg::IORS_OP_WRITE);
  wire logic do_set = (req.op == iors_pkg::IORS_OP_SET_BIT) && bit_range;
  wire logic do_clear = (req.op == iors_pkg::IORS_OP_CLEAR_BIT) && bit_range;
  wire logic do_read = (req.op == iors_pkg::IORS_OP_READ);
  wire logic do_test = (req.op == iors_pkg::IORS_OP_TEST_BIT) && bit_range;
  wire logic [7:0] wmask = write_mask(addr);
  wire logic [7:0] cmask = clear_mask(addr);
  wire logic [7:0] cur = read_value(addr);

  // A bit set writes one only at the addressed bit; on a flag that clears it,
  // while a zero is written to every other flag so that none is cleared.
  wire logic [7:0] op_ones = do_write ? req.wdata : (do_set ? bit_onehot : 8'h00);
  wire logic [7:0] op_clear = cmask & op_ones;
  wire logic [7:0] bit_op_mask = (do_set || do_clear) ? (wmask & bit_onehot) : 8'h00;
  wire logic [7:0] op_mask = do_write ? wmask : bit_op_mask;
  wire logic [7:0] op_value = do_clear ? 8'h00 : op_ones;

  ////////////////////////////////////////////////////////////////////////////
  // Hardware flag events per address, which win over a clear in the same cycle.

  function automatic logic [7:0] event_set(input logic [5:0] a);
    case (a)
      `IORS_CONVERTER_CONTROL_STATUS_A:
        event_set = {3'b000, events.converter_done, 4'h0};
      `IORS_COMPARATOR_CONTROL_STATUS:
        event_set = {3'b000, events.comparator_event, 4'h0};
      `IORS_WATCHDOG_CONTROL: event_set = {events.watchdog_event, 7'h00};
      `IORS_RESET_CAUSE_FLAGS: event_set = {4'h0, events.reset_causes};
      `IORS_TIMER_INTERRUPT_FLAGS:
        event_set = {4'h0, events.timer_match_b, events.timer_match_a, events.timer_overflow, 1'b0};
      `IORS_EXTERNAL_INTERRUPT_FLAGS:
        event_set = {1'b0, events.external_event, events.pin_change_event, 5'h00};
      default: event_set = 8'h00;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register update.

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 64; i++) begin
        regs[i] <= `IORS_RESET_VALUE;
      end
    end else begin
      for (int i = 0; i < 64; i++) begin
        if (6'(i) == addr) begin
          regs[i] <= ((regs[i] & ~op_mask) | (op_value & op_mask) & ~cmask)
                     & ~op_clear | event_set(6'(i));
        end else begin
          regs[i] <= regs[i] | event_set(6'(i));
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Answer to the core.

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rsp <= '0;
    end else begin
      rsp.rdata <= do_read ? cur : 8'h00;
      rsp.bit_value <= do_test ? cur[req.bit_sel] : 1'b0;
      rsp.bit_valid <= do_test;
    end
  end

  assign port_direction = regs[`IORS_PORT_DIRECTION];
  assign port_output_latch = regs[`IORS_PORT_OUTPUT_LATCH];
  assign core_status_flags = regs[`IORS_CORE_STATUS_FLAGS];
  assign stack_pointer_low = regs[`IORS_STACK_POINTER_LOW];

endmodule // iors_space

// ==== verif/iors_space_properties.sv ====
// Port checks of the I/O register space, bound to its top module.
`include "iors_regs.svh"
module iors_space_checker (
  input wire logic sys_clk, // Core clock.
  input wire logic arst_n, // Reset, active low.
  input wire iors_pkg::iors_req_type req, // Core request.
  input wire iors_pkg::iors_rsp_type rsp, // Registered answer.
  input wire logic [7:0] port_direction, // Direction latch.
  input wire logic [7:0] port_output_latch, // Output latch.
  input wire logic [7:0] core_status_flags, // Status register.
  input wire logic [7:0] stack_pointer_low // Stack pointer low byte.
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  wire logic [7:0] bit_mask = 8'h01 << req.bit_sel;
  wire logic dir_bit = port_direction[req.bit_sel];
  wire logic op_rd = req.op == iors_pkg::IORS_OP_READ;
  wire logic op_wr = req.op == iors_pkg::IORS_OP_WRITE;
  wire logic op_set = req.op == iors_pkg::IORS_OP_SET_BIT;
  wire logic op_clr = req.op == iors_pkg::IORS_OP_CLEAR_BIT;
  wire logic op_tst = req.op == iors_pkg::IORS_OP_TEST_BIT;
  wire logic low = req.addr <= `IORS_BIT_ACCESS_TOP;
  property p_bit_refused;
    (op_set || op_clr || op_tst) && !low |=> !rsp.bit_valid;
  endproperty
  a_bit_refused: assert property (p_bit_refused)
    else $error("bit op answered above range");
  property p_test_valid;
    op_tst && low |=> rsp.bit_valid;
  endproperty
  a_test_valid: assert property (p_test_valid) else $error("bit test not answered");
  property p_test_value;
    op_tst && req.addr == `IORS_PORT_DIRECTION |=> rsp.bit_value == $past(dir_bit);
  endproperty
  a_test_value: assert property (p_test_value) else $error("bit test value wrong");
  property p_set_bit;
    op_set && req.addr == `IORS_PORT_OUTPUT_LATCH |=> port_output_latch ==
      (($past(port_output_latch) | $past(bit_mask)) & `IORS_MASK_SIX_BITS);
  endproperty
  a_set_bit: assert property (p_set_bit) else $error("bit set wrong");
  property p_clr_bit;
    op_clr && req.addr == `IORS_PORT_DIRECTION |=>
      port_direction == ($past(port_direction) & ~$past(bit_mask));
  endproperty
  a_clr_bit: assert property (p_clr_bit) else $error("bit clear wrong");
  property p_status_write;
    op_wr && req.addr == `IORS_CORE_STATUS_FLAGS |=> core_status_flags == $past(req.wdata);
  endproperty
  a_status_write: assert property (p_status_write) else $error("status write lost");
  property p_status_hold;
    !(op_wr && req.addr == `IORS_CORE_STATUS_FLAGS) |=> $stable(core_status_flags);
  endproperty
  a_status_hold: assert property (p_status_hold) else $error("status changed");
  property p_sp_read;
    op_rd && req.addr == `IORS_STACK_POINTER_LOW |=> rsp.rdata == $past(stack_pointer_low);
  endproperty
  a_sp_read: assert property (p_sp_read) else $error("stack pointer read wrong");
  property p_idle_rsp;
    !op_rd && !op_tst |=> rsp.rdata == 8'h00 && !rsp.bit_valid;
  endproperty
  a_idle_rsp: assert property (p_idle_rsp) else $error("answer without read");
  c_set: cover property (op_set && low);
  c_test: cover property (op_tst && low);
  c_refused: cover property (op_set && !low);
endmodule // iors_space_checker
bind iors_space iors_space_checker u_iors_space_checker (.sys_clk(sys_clk), .arst_n(arst_n),
  .req(req), .rsp(rsp), .port_direction(port_direction), .port_output_latch(port_output_latch),
  .core_status_flags(core_status_flags), .stack_pointer_low(stack_pointer_low));

// ==== verif/iors_core_model.sv ====
// Core-side model that issues I/O and bit requests, one per clock.
module iors_core_model (
  input wire logic sys_clk, // Core clock.
  input wire iors_pkg::iors_rsp_type rsp, // Answer from the register space.
  output iors_pkg::iors_req_type req // Request to the register space.
);
  timeunit 1ns;
  timeprecision 1ns;
  initial req = '0;
  // The request is held until the next call, so calls run back to back.
  task automatic io_op(input iors_pkg::iors_op_type op, input logic [5:0] addr,
      input logic [2:0] bsel, input logic [7:0] wdata, input logic [7:0] wmask,
      output iors_pkg::iors_rsp_type ans);
    if (op == iors_pkg::IORS_OP_WRITE && addr inside {[6'h00:6'h02], [6'h09:6'h13],
        [6'h19:6'h1c], 6'h1f, 6'h20, [6'h22:6'h25], 6'h27, [6'h2a:6'h2d], 6'h30, 6'h3c,
        6'h3e}) op = iors_pkg::IORS_OP_NONE;
    req = '{op, addr, bsel, wdata & wmask};
    @(posedge sys_clk);
    #1;
    ans = rsp;
  endtask
  // Idle fields are scrambled so that stale values cannot be relied on.
  task automatic io_idle();
    req = '{iors_pkg::IORS_OP_NONE, ~req.addr, ~req.bit_sel, ~req.wdata};
    @(posedge sys_clk);
    #1;
  endtask
endmodule // iors_core_model

// ==== verif/iors_space_tb_top.sv ====
// Self-checking bench of the I/O register space.
module iors_space_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  iors_pkg::iors_req_type req;
  iors_pkg::iors_rsp_type rsp, ans;
  iors_pkg::iors_event_type events = '0;
  logic [15:0] converter_result = 16'h1234;
  logic [7:0] timer_value = 8'hc7;
  logic [5:0] port_pins = 6'h2d;
  logic [7:0] port_direction, port_output_latch, core_status_flags, stack_pointer_low;
  logic [5:0] rw_addr [6] = '{6'h03, 6'h07, 6'h2f, 6'h35, 6'h3b, 6'h3d};
  logic [7:0] rw_mask [6] = '{8'h47, 8'h63, 8'hf3, 8'h7b, 8'h60, 8'hff};
  int num_errors = 0;
  int n_tests = 0;
  always #20 sys_clk = ~sys_clk;
  iors_space u_iors_space (.sys_clk(sys_clk), .arst_n(arst_n), .req(req), .events(events),
    .converter_result(converter_result), .timer_value(timer_value), .port_pins(port_pins),
    .rsp(rsp), .port_direction(port_direction), .port_output_latch(port_output_latch),
    .core_status_flags(core_status_flags), .stack_pointer_low(stack_pointer_low));
  iors_core_model u_iors_core_model (.sys_clk(sys_clk), .rsp(rsp), .req(req));
  task automatic stop_test();
    if (num_errors == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t byte %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t bit %b expected %b", $time, got, exp);
    end
  endtask
  task automatic op(input iors_pkg::iors_op_type o, input logic [5:0] a, input logic [2:0] b,
      input logic [7:0] d);
    u_iors_core_model.io_op(o, a, b, d, 8'hff, ans);
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    op(iors_pkg::IORS_OP_READ, a, 3'd0, 8'h00);
    check_byte(ans.rdata, e);
  endtask
  initial begin
    #20000;
    num_errors++;
    stop_test();
  end
  initial begin
    repeat (5) @(posedge sys_clk);
    #1;
    arst_n = 1'b1;
    foreach (rw_addr[i]) rd(rw_addr[i], 8'h00);
    foreach (rw_addr[i]) begin
      u_iors_core_model.io_op(iors_pkg::IORS_OP_WRITE, rw_addr[i], 3'd0, 8'ha5, rw_mask[i],
        ans);
      rd(rw_addr[i], 8'ha5 & rw_mask[i]);
    end
    check_byte(stack_pointer_low, 8'ha5);
    rd(6'h04, 8'h34);
    rd(6'h05, 8'h12);
    rd(6'h32, 8'hc7);
    rd(6'h16, 8'h2d);
    rd(6'h3e, 8'h00);
    op(iors_pkg::IORS_OP_WRITE, 6'h3f, 3'd0, 8'h5a);
    op(iors_pkg::IORS_OP_SET_BIT, 6'h3f, 3'd0, 8'h00);
    op(iors_pkg::IORS_OP_TEST_BIT, 6'h3f, 3'd1, 8'h00);
    check_bit(ans.bit_valid, 1'b0);
    check_byte(core_status_flags, 8'h5a);
    op(iors_pkg::IORS_OP_SET_BIT, 6'h18, 3'd3, 8'h00);
    op(iors_pkg::IORS_OP_SET_BIT, 6'h18, 3'd5, 8'h00);
    check_byte(port_output_latch, 8'h28);
    op(iors_pkg::IORS_OP_CLEAR_BIT, 6'h18, 3'd3, 8'h00);
    rd(6'h18, 8'h20);
    op(iors_pkg::IORS_OP_WRITE, 6'h17, 3'd0, 8'h05);
    check_byte(port_direction, 8'h05);
    for (int i = 0; i < 8; i++) begin
      op(iors_pkg::IORS_OP_TEST_BIT, 6'h17, i[2:0], 8'h00);
      check_bit(ans.bit_valid, 1'b1);
      check_bit(ans.bit_value, i == 0 || i == 2);
    end
    op(iors_pkg::IORS_OP_CLEAR_BIT, 6'h17, 3'd2, 8'h00);
    rd(6'h17, 8'h01);
    events = '{converter_done: 1'b1, timer_overflow: 1'b1, timer_match_a: 1'b1, default: '0};
    u_iors_core_model.io_idle();
    events = '0;
    op(iors_pkg::IORS_OP_WRITE, 6'h06, 3'd0, 8'h01);
    rd(6'h06, 8'h11);
    op(iors_pkg::IORS_OP_SET_BIT, 6'h06, 3'd2, 8'h00);
    op(iors_pkg::IORS_OP_CLEAR_BIT, 6'h06, 3'd4, 8'h00);
    rd(6'h06, 8'h15);
    op(iors_pkg::IORS_OP_SET_BIT, 6'h06, 3'd4, 8'h00);
    rd(6'h06, 8'h05);
    op(iors_pkg::IORS_OP_SET_BIT, 6'h38, 3'd1, 8'h00);
    rd(6'h38, 8'h06);
    op(iors_pkg::IORS_OP_WRITE, 6'h38, 3'd0, 8'h02);
    rd(6'h38, 8'h04);
    // Raise every remaining flag source once, with reset causes 0 and 3 only, then clear one flag in each register they set, through that register.
    events = '{watchdog_event: 1'b1, comparator_event: 1'b1, external_event: 1'b1,
      pin_change_event: 1'b1, timer_match_b: 1'b1, reset_causes: 4'h9, default: '0};
    u_iors_core_model.io_idle();
    // An event in the cycle of its own clear must win, or a pending interrupt is lost.
    events = '{timer_overflow: 1'b1, default: '0};
    op(iors_pkg::IORS_OP_WRITE, 6'h38, 3'd0, 8'h0a);
    events = '0;
    rd(6'h38, 8'h06);
    rd(6'h21, 8'h80);
    op(iors_pkg::IORS_OP_SET_BIT, 6'h21, 3'd7, 8'h00);
    rd(6'h21, 8'h80);
    op(iors_pkg::IORS_OP_WRITE, 6'h21, 3'd0, 8'h85);
    rd(6'h21, 8'h05);
    op(iors_pkg::IORS_OP_CLEAR_BIT, 6'h08, 3'd4, 8'h00);
    op(iors_pkg::IORS_OP_SET_BIT, 6'h08, 3'd3, 8'h00);
    rd(6'h08, 8'h18);
    op(iors_pkg::IORS_OP_SET_BIT, 6'h08, 3'd4, 8'h00);
    rd(6'h08, 8'h08);
    op(iors_pkg::IORS_OP_TEST_BIT, 6'h08, 3'd3, 8'h00);
    check_bit(ans.bit_value, 1'b1);
    op(iors_pkg::IORS_OP_WRITE, 6'h34, 3'd0, 8'h01);
    rd(6'h34, 8'h08);
    op(iors_pkg::IORS_OP_WRITE, 6'h3a, 3'd0, 8'h20);
    rd(6'h3a, 8'h40);
    // A reset in mid-run must bring every register back to zero.
    arst_n = 1'b0;
    u_iors_core_model.io_idle();
    u_iors_core_model.io_idle();
    arst_n = 1'b1;
    rd(6'h08, 8'h00);
    check_byte(core_status_flags, 8'h00);
    check_byte(stack_pointer_low, 8'h00);
    u_iors_core_model.io_idle();
    stop_test();
  end
endmodule // iors_space_tb_top
